// ===== rtl/epv_core.sv
// exception and interrupt priority resolver and handler vectoring
// Summary of operation
// - debug stop, priority 2, debug-supplied address
// - unrecoverable, priority 3, base+0x00, offender
// - data bus error, priority 5, base+0x08
// - fetch bus error, priority 6, base+0x0C
// - NMI, priority 7, base+0x10
// - IRQ3..0 at priorities 8..11, handler addresses taken from irq_addr_3..irq_addr_0
// - instruction address fault, priority 12, base+0x14
// - breakpoint, priority 15, base+0x1C
// - illegal opcode, priority 16, base+0x20
// - unimplemented, priority 17, base+0x24
// - privilege violation, priority 18, base+0x28
// - floating-point exception never raised
// - absent coprocessor never raised; coprocessor without unit raises unimplemented
// - supervisor call, priority 21, base+0x100, PC+2
// - data read fault, priority 22, base+0x34
// - data write fault, priority 23, base+0x38
// - reset first, fixed address, undefined return
// - listed unsupported instructions raise unimplemented
// - smallest priority number pending wins
`timescale 1ns/100ps
`default_nettype none
module epv_core
    import epv_pkg::*;
#(
    parameter int ADDR_W = epv_pkg::EPV_ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] exception_vector_base,
    input wire logic [ADDR_W-1:0] pc_offending,
    input wire logic [ADDR_W-1:0] pc_first_nc,
    input wire logic ev_reset,
    input wire logic ev_debug_stop,
    input wire logic [ADDR_W-1:0] debug_handler_addr,
    input wire logic ev_unrecoverable,
    input wire logic ev_bus_err_data,
    input wire logic ev_bus_err_insn,
    input wire logic nmi_pin,
    input wire logic [3:0] irq_req,
    input wire logic [ADDR_W-1:0] irq_addr_3,
    input wire logic [ADDR_W-1:0] irq_addr_2,
    input wire logic [ADDR_W-1:0] irq_addr_1,
    input wire logic [ADDR_W-1:0] irq_addr_0,
    input wire logic ev_insn_addr,
    input wire logic ev_breakpoint,
    input wire logic ev_illegal,
    input wire logic is_simd,
    input wire logic is_coproc,
    input wire logic coproc_present,
    input wire logic is_java_op,
    input wire logic is_tlb_op,
    input wire logic is_cache_op,
    input wire logic ev_priv,
    input wire logic ev_scall,
    input wire logic ev_daddr_rd,
    input wire logic ev_daddr_wr,
    input wire logic take_ack,
    output logic take_ff,
    output logic [4:0] take_pri_ff,
    output logic [ADDR_W-1:0] handler_addr_ff,
    output logic [ADDR_W-1:0] return_addr_ff,
    output logic return_valid_ff
);
    import epv_pkg::*;

    // ******************************
    // pin synchronisers
    // ******************************
    logic nmi_s1_ff;
    logic nmi_s2_ff;
    logic [3:0] irq_s1_ff;
    logic [3:0] irq_s2_ff;
    logic nxt_nmi_s1;
    logic nxt_nmi_s2;
    logic [3:0] nxt_irq_s1;
    logic [3:0] nxt_irq_s2;

    always_comb
    begin
        nxt_nmi_s1 = nmi_pin;
        nxt_nmi_s2 = nmi_s1_ff;
        nxt_irq_s1 = irq_req;
        nxt_irq_s2 = irq_s1_ff;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_s1_ff <= 1'b0;
            nmi_s2_ff <= 1'b0;
            irq_s1_ff <= 4'h0;
            irq_s2_ff <= 4'h0;
        end
        else
        begin
            nmi_s1_ff <= nxt_nmi_s1;
            nmi_s2_ff <= nxt_nmi_s2;
            irq_s1_ff <= nxt_irq_s1;
            irq_s2_ff <= nxt_irq_s2;
        end
    end

    // ******************************
    // instruction class decode
    // ******************************
    logic ev_unimpl;

    epv_unimpl_decode u_unimpl
    (
        .is_simd(is_simd),
        .is_coproc(is_coproc),
        .coproc_present(coproc_present),
        .is_java_op(is_java_op),
        .is_tlb_op(is_tlb_op),
        .is_cache_op(is_cache_op),
        .unimpl(ev_unimpl)
    );

    // absent coprocessor never raised: ev_coproc is tied low
    logic ev_coproc;
    assign ev_coproc = 1'b0;
    // coprocessor instructions without a unit are counted as unimplemented above;
    // the absent-coprocessor slot is never reached, since ev_coproc is tied low
    logic ev_coproc_abs;
    assign ev_coproc_abs = is_coproc & coproc_present & ev_coproc;

    // ******************************
    // priority resolve
    // ******************************
    logic [4:0] win_pri;
    logic [ADDR_W-1:0] win_addr;
    epv_ret_t win_ret;
    logic win_plus2;

    function automatic logic [ADDR_W-1:0] vec(input logic [ADDR_W-1:0] base,
                                              input logic [31:0] ofs);
        vec = base + ofs[ADDR_W-1:0];
    endfunction

    always_comb
    begin
        win_pri = EPV_PRI_NONE;
        win_addr = '0;
        win_ret = EPV_RET_FIRST_NC;
        win_plus2 = 1'b0;
        // fixed chain: first true term wins; slots 4,13,14,19,24..28 absent
        if (ev_reset)
        begin
            win_pri = EPV_PRI_RESET;
            win_addr = EPV_RESET_ADDR[ADDR_W-1:0];
            win_ret = EPV_RET_UNDEF;
        end
        else if (ev_debug_stop)
        begin
            win_pri = EPV_PRI_DEBUG;
            win_addr = debug_handler_addr;
        end
        else if (ev_unrecoverable)
        begin
            win_pri = EPV_PRI_UNRECOV;
            win_addr = vec(exception_vector_base, EPV_OFS_UNRECOV);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_bus_err_data)
        begin
            win_pri = EPV_PRI_BUS_DATA;
            win_addr = vec(exception_vector_base, EPV_OFS_BUS_DATA);
        end
        else if (ev_bus_err_insn)
        begin
            win_pri = EPV_PRI_BUS_INSN;
            win_addr = vec(exception_vector_base, EPV_OFS_BUS_INSN);
        end
        else if (nmi_s2_ff)
        begin
            win_pri = EPV_PRI_NMI;
            win_addr = vec(exception_vector_base, EPV_OFS_NMI);
        end
        else if (irq_s2_ff[3])
        begin
            win_pri = EPV_PRI_IRQ3;
            win_addr = irq_addr_3;
        end
        else if (irq_s2_ff[2])
        begin
            win_pri = EPV_PRI_IRQ3 + 5'h01;
            win_addr = irq_addr_2;
        end
        else if (irq_s2_ff[1])
        begin
            win_pri = EPV_PRI_IRQ3 + 5'h02;
            win_addr = irq_addr_1;
        end
        else if (irq_s2_ff[0])
        begin
            win_pri = EPV_PRI_IRQ0;
            win_addr = irq_addr_0;
        end
        else if (ev_insn_addr)
        begin
            win_pri = EPV_PRI_INSN_ADDR;
            win_addr = vec(exception_vector_base, EPV_OFS_INSN_ADDR);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_breakpoint)
        begin
            win_pri = EPV_PRI_BREAKPOINT;
            win_addr = vec(exception_vector_base, EPV_OFS_BREAKPOINT);
        end
        else if (ev_illegal)
        begin
            win_pri = EPV_PRI_ILLEGAL;
            win_addr = vec(exception_vector_base, EPV_OFS_ILLEGAL);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_unimpl)
        begin
            win_pri = EPV_PRI_UNIMPL;
            win_addr = vec(exception_vector_base, EPV_OFS_UNIMPL);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_priv)
        begin
            win_pri = EPV_PRI_PRIV;
            win_addr = vec(exception_vector_base, EPV_OFS_PRIV);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_coproc_abs)
        begin
            win_pri = EPV_PRI_COPROC;
            win_addr = vec(exception_vector_base, EPV_OFS_COPROC);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_scall)
        begin
            win_pri = EPV_PRI_SCALL;
            win_addr = vec(exception_vector_base, EPV_OFS_SCALL);
            win_ret = EPV_RET_OFFEND;
            win_plus2 = 1'b1;
        end
        else if (ev_daddr_rd)
        begin
            win_pri = EPV_PRI_DADDR_RD;
            win_addr = vec(exception_vector_base, EPV_OFS_DADDR_RD);
            win_ret = EPV_RET_OFFEND;
        end
        else if (ev_daddr_wr)
        begin
            win_pri = EPV_PRI_DADDR_WR;
            win_addr = vec(exception_vector_base, EPV_OFS_DADDR_WR);
            win_ret = EPV_RET_OFFEND;
        end
    end

    // ******************************
    // take handshake
    // ******************************
    epv_state_t state_ff;
    epv_state_t nxt_state;
    logic nxt_take;
    logic [4:0] nxt_take_pri;
    logic [ADDR_W-1:0] nxt_handler_addr;
    logic [ADDR_W-1:0] nxt_return_addr;
    logic nxt_return_valid;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_take = take_ff;
        nxt_take_pri = take_pri_ff;
        nxt_handler_addr = handler_addr_ff;
        nxt_return_addr = return_addr_ff;
        nxt_return_valid = return_valid_ff;
        unique case (state_ff)
            EPV_ST_IDLE:
            begin
                if (win_pri != EPV_PRI_NONE)
                begin
                    nxt_state = EPV_ST_TAKEN;
                    nxt_take = 1'b1;
                    nxt_take_pri = win_pri;
                    nxt_handler_addr = win_addr;
                    nxt_return_valid = (win_ret != EPV_RET_UNDEF);
                    if (win_ret == EPV_RET_OFFEND)
                    begin
                        nxt_return_addr = win_plus2 ? (pc_offending
                            + EPV_SCALL_RET_INC[ADDR_W-1:0]) : pc_offending;
                    end
                    else if (win_ret == EPV_RET_FIRST_NC)
                    begin
                        nxt_return_addr = pc_first_nc;
                    end
                    else
                    begin
                        nxt_return_addr = '0;
                    end
                end
            end
            EPV_ST_TAKEN:
            begin
                if (take_ack)
                begin
                    nxt_state = EPV_ST_IDLE;
                    nxt_take = 1'b0;
                end
            end
            default:
            begin
                nxt_state = EPV_ST_IDLE;
                nxt_take = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= EPV_ST_IDLE;
            take_ff <= 1'b0;
            take_pri_ff <= EPV_PRI_NONE;
            handler_addr_ff <= '0;
            return_addr_ff <= '0;
            return_valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            take_ff <= nxt_take;
            take_pri_ff <= nxt_take_pri;
            handler_addr_ff <= nxt_handler_addr;
            return_addr_ff <= nxt_return_addr;
            return_valid_ff <= nxt_return_valid;
        end
    end

    // ******************************
    // checks
    // ******************************
    chk_reset_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == EPV_ST_IDLE && ev_reset) |=> (take_pri_ff == EPV_PRI_RESET
        && handler_addr_ff == EPV_RESET_ADDR[ADDR_W-1:0] && !return_valid_ff))
        else $error("reset not vectored to fixed address");
    chk_debug_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == EPV_ST_IDLE && !ev_reset && ev_debug_stop)
        |=> (take_pri_ff == EPV_PRI_DEBUG && handler_addr_ff == $past(debug_handler_addr)
        && return_addr_ff == $past(pc_first_nc)))
        else $error("debug stop vector or return wrong");
    chk_unrecov_vec: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == EPV_ST_IDLE && !ev_reset && !ev_debug_stop && ev_unrecoverable)
        |=> (handler_addr_ff == $past(exception_vector_base)
        && return_addr_ff == $past(pc_offending)))
        else $error("unrecoverable vector wrong");
    chk_scall_ret: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take_pri_ff == EPV_PRI_SCALL && $rose(take_ff))
        |-> (return_addr_ff == $past(pc_offending) + 32'h2))
        else $error("supervisor call return not plus two");
    chk_nmi_sync: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == EPV_ST_IDLE && nmi_s2_ff && win_pri == EPV_PRI_NMI)
        |=> (handler_addr_ff == $past(exception_vector_base) + 32'h10))
        else $error("nmi vector wrong");
    chk_irq_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (win_pri >= EPV_PRI_IRQ3 && win_pri <= EPV_PRI_IRQ0)
        |-> (win_pri == EPV_PRI_IRQ0 - 5'(irq_s2_ff[3] ? 3 : irq_s2_ff[2] ? 2
        : irq_s2_ff[1] ? 1 : 0)))
        else $error("interrupt level order wrong");
    chk_no_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
        take_ff |-> !(take_pri_ff inside {5'h04, 5'h0D, 5'h0E, 5'h13,
        [5'h18:5'h1C]}))
        else $error("reserved slot raised");
    chk_take_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (take_ff && !take_ack) |=> (take_ff && $stable(take_pri_ff)
        && $stable(handler_addr_ff)))
        else $error("taken event changed before acknowledge");
    chk_unimpl_vec: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == EPV_ST_IDLE && win_pri == EPV_PRI_UNIMPL)
        |=> (handler_addr_ff == $past(exception_vector_base) + 32'h24))
        else $error("unimplemented vector wrong");
endmodule
`default_nettype wire

// ===== rtl/epv_pkg.sv
// constants and types shared by the exception priority and vectoring block
package epv_pkg;
    localparam int EPV_ADDR_W = 32;
    localparam int EPV_NUM_EV = 21;
    localparam logic [31:0] EPV_RESET_ADDR = 32'h0800_0000;
    localparam logic [31:0] EPV_OFS_UNRECOV = 32'h0000_0000;
    localparam logic [31:0] EPV_OFS_BUS_DATA = 32'h0000_0008;
    localparam logic [31:0] EPV_OFS_BUS_INSN = 32'h0000_000C;
    localparam logic [31:0] EPV_OFS_NMI = 32'h0000_0010;
    localparam logic [31:0] EPV_OFS_INSN_ADDR = 32'h0000_0014;
    localparam logic [31:0] EPV_OFS_BREAKPOINT = 32'h0000_001C;
    localparam logic [31:0] EPV_OFS_ILLEGAL = 32'h0000_0020;
    localparam logic [31:0] EPV_OFS_UNIMPL = 32'h0000_0024;
    localparam logic [31:0] EPV_OFS_PRIV = 32'h0000_0028;
    localparam logic [31:0] EPV_OFS_FPU = 32'h0000_002C;
    localparam logic [31:0] EPV_OFS_COPROC = 32'h0000_0030;
    localparam logic [31:0] EPV_OFS_SCALL = 32'h0000_0100;
    localparam logic [31:0] EPV_OFS_DADDR_RD = 32'h0000_0034;
    localparam logic [31:0] EPV_OFS_DADDR_WR = 32'h0000_0038;
    localparam logic [31:0] EPV_SCALL_RET_INC = 32'h0000_0002;
    localparam logic [4:0] EPV_PRI_NONE = 5'h00;
    localparam logic [4:0] EPV_PRI_RESET = 5'h01;
    localparam logic [4:0] EPV_PRI_DEBUG = 5'h02;
    localparam logic [4:0] EPV_PRI_UNRECOV = 5'h03;
    localparam logic [4:0] EPV_PRI_BUS_DATA = 5'h05;
    localparam logic [4:0] EPV_PRI_BUS_INSN = 5'h06;
    localparam logic [4:0] EPV_PRI_NMI = 5'h07;
    localparam logic [4:0] EPV_PRI_IRQ3 = 5'h08;
    localparam logic [4:0] EPV_PRI_IRQ0 = 5'h0B;
    localparam logic [4:0] EPV_PRI_INSN_ADDR = 5'h0C;
    localparam logic [4:0] EPV_PRI_BREAKPOINT = 5'h0F;
    localparam logic [4:0] EPV_PRI_ILLEGAL = 5'h10;
    localparam logic [4:0] EPV_PRI_UNIMPL = 5'h11;
    localparam logic [4:0] EPV_PRI_PRIV = 5'h12;
    localparam logic [4:0] EPV_PRI_COPROC = 5'h14;
    localparam logic [4:0] EPV_PRI_SCALL = 5'h15;
    localparam logic [4:0] EPV_PRI_DADDR_RD = 5'h16;
    localparam logic [4:0] EPV_PRI_DADDR_WR = 5'h17;
    typedef enum logic [2:0]
    {
        EPV_RET_UNDEF = 3'b001,
        EPV_RET_FIRST_NC = 3'b010,
        EPV_RET_OFFEND = 3'b100
    } epv_ret_t;
    typedef enum logic [1:0]
    {
        EPV_ST_IDLE = 2'b01,
        EPV_ST_TAKEN = 2'b10
    } epv_state_t;
endpackage

// ===== rtl/epv_unimpl_decode.sv
// decoder flagging instruction classes that raise the unimplemented exception
`timescale 1ns/100ps
`default_nettype none
module epv_unimpl_decode
(
    input wire logic is_simd,
    input wire logic is_coproc,
    input wire logic coproc_present,
    input wire logic is_java_op,
    input wire logic is_tlb_op,
    input wire logic is_cache_op,
    output logic unimpl
);
    always_comb
    begin
        // SIMD, coprocessor without unit, java/tlb/cache classes
        unimpl = is_simd | (is_coproc & ~coproc_present) | is_java_op | is_tlb_op
            | is_cache_op;
    end
endmodule
`default_nettype wire

// ===== dv/epv_far_model.sv
// far-side model: interrupt controller pins and on-chip debugger stop request
`timescale 1ns/100ps
`default_nettype none
module epv_far_model
#(
    parameter logic [31:0] IRQ_VEC_BASE = 32'h0002_0000,
    parameter logic [31:0] DBG_ADDR = 32'h0003_0040
)
(
    input wire logic [3:0] want_irq,
    input wire logic want_nmi,
    input wire logic want_dbg,
    output logic [3:0] irq_req,
    output logic nmi_pin,
    output logic ev_debug_stop,
    output logic [31:0] debug_handler_addr,
    output logic [31:0] irq_addr_3,
    output logic [31:0] irq_addr_2,
    output logic [31:0] irq_addr_1,
    output logic [31:0] irq_addr_0
);
    // ************************************************************
    // request pins and handler addresses
    // ************************************************************
    // an address is only good while its request stands, else inverted
    function automatic logic [31:0] vec(input logic on, input logic [31:0] a);
        vec = on ? a : ~a;
    endfunction

    always_comb
    begin
        irq_req = want_irq;
        nmi_pin = want_nmi;
        ev_debug_stop = want_dbg;
        debug_handler_addr = vec(want_dbg, DBG_ADDR);
        irq_addr_3 = vec(want_irq[3], IRQ_VEC_BASE + 32'h0000_0030);
        irq_addr_2 = vec(want_irq[2], IRQ_VEC_BASE + 32'h0000_0020);
        irq_addr_1 = vec(want_irq[1], IRQ_VEC_BASE + 32'h0000_0010);
        irq_addr_0 = vec(want_irq[0], IRQ_VEC_BASE);
    end
endmodule
`default_nettype wire

// ===== dv/epv_core_tb.sv
// self-checking testbench for the exception priority and vectoring block
`timescale 1ns/100ps
`default_nettype none
module epv_core_tb;
    import epv_pkg::*;
    localparam logic [31:0] IRQ_BASE = 32'h0002_0000;
    localparam logic [31:0] DBG_ADDR = 32'h0003_0040;
    localparam logic [4:0] PRI_TAB [0:17] = '{EPV_PRI_RESET, EPV_PRI_DEBUG, EPV_PRI_UNRECOV,
        EPV_PRI_BUS_DATA, EPV_PRI_BUS_INSN, EPV_PRI_NMI, EPV_PRI_IRQ3, 5'h09, 5'h0A,
        EPV_PRI_IRQ0, EPV_PRI_INSN_ADDR, EPV_PRI_BREAKPOINT, EPV_PRI_ILLEGAL, EPV_PRI_UNIMPL,
        EPV_PRI_PRIV, EPV_PRI_SCALL, EPV_PRI_DADDR_RD, EPV_PRI_DADDR_WR};
    localparam logic [31:0] OFS_TAB [0:17] = '{32'h0, 32'h0, EPV_OFS_UNRECOV, EPV_OFS_BUS_DATA,
        EPV_OFS_BUS_INSN, EPV_OFS_NMI, 32'h0, 32'h0, 32'h0, 32'h0, EPV_OFS_INSN_ADDR,
        EPV_OFS_BREAKPOINT, EPV_OFS_ILLEGAL, EPV_OFS_UNIMPL, EPV_OFS_PRIV, EPV_OFS_SCALL,
        EPV_OFS_DADDR_RD, EPV_OFS_DADDR_WR};

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [17:0] ev_on = 18'h00000;
    logic [5:0] cls = 6'h00;
    logic take_ack = 1'b0;
    logic [31:0] base = 32'h0001_0000;
    logic [31:0] pc_off = 32'h0000_1230;
    logic [31:0] pc_nc = 32'h0000_1234;
    logic [3:0] irq_req;
    logic nmi_pin;
    logic ev_debug_stop;
    logic [31:0] dbg_addr;
    logic [31:0] irq_a3, irq_a2, irq_a1, irq_a0;
    logic take_ff;
    logic [4:0] take_pri_ff;
    logic [31:0] handler_addr_ff;
    logic [31:0] return_addr_ff;
    logic return_valid_ff;
    int errors = 0;
    int check_count = 0;

    always #2 clk_sys = ~clk_sys;

    epv_far_model #(.IRQ_VEC_BASE(IRQ_BASE), .DBG_ADDR(DBG_ADDR)) i_epv_far_model
    (
        .want_irq({ev_on[6], ev_on[7], ev_on[8], ev_on[9]}),
        .want_nmi(ev_on[5]),
        .want_dbg(ev_on[1]),
        .irq_req(irq_req),
        .nmi_pin(nmi_pin),
        .ev_debug_stop(ev_debug_stop),
        .debug_handler_addr(dbg_addr),
        .irq_addr_3(irq_a3),
        .irq_addr_2(irq_a2),
        .irq_addr_1(irq_a1),
        .irq_addr_0(irq_a0)
    );

    epv_core i_epv_core
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .exception_vector_base(base),
        .pc_offending(pc_off), .pc_first_nc(pc_nc), .ev_reset(ev_on[0]),
        .ev_debug_stop(ev_debug_stop), .debug_handler_addr(dbg_addr),
        .ev_unrecoverable(ev_on[2]), .ev_bus_err_data(ev_on[3]), .ev_bus_err_insn(ev_on[4]),
        .nmi_pin(nmi_pin), .irq_req(irq_req), .irq_addr_3(irq_a3), .irq_addr_2(irq_a2),
        .irq_addr_1(irq_a1), .irq_addr_0(irq_a0), .ev_insn_addr(ev_on[10]),
        .ev_breakpoint(ev_on[11]), .ev_illegal(ev_on[12]), .is_simd(ev_on[13] | cls[0]),
        .is_coproc(cls[1]), .coproc_present(cls[2]), .is_java_op(cls[3]),
        .is_tlb_op(cls[4]), .is_cache_op(cls[5]), .ev_priv(ev_on[14]), .ev_scall(ev_on[15]),
        .ev_daddr_rd(ev_on[16]), .ev_daddr_wr(ev_on[17]), .take_ack(take_ack),
        .take_ff(take_ff), .take_pri_ff(take_pri_ff), .handler_addr_ff(handler_addr_ff),
        .return_addr_ff(return_addr_ff), .return_valid_ff(return_valid_ff)
    );

    // ************************************************************
    // expectations and shared checks
    // ************************************************************
    function automatic logic [31:0] exp_hdl(input int k);
        if (k == 0) exp_hdl = EPV_RESET_ADDR;
        else if (k == 1) exp_hdl = DBG_ADDR;
        else if (k >= 6 && k <= 9) exp_hdl = IRQ_BASE + (32'(9 - k) << 4);
        else exp_hdl = base + OFS_TAB[k];
    endfunction

    function automatic logic [31:0] exp_ret(input int k);
        if (k == 0) exp_ret = 32'h0000_0000;
        else if (k == 15) exp_ret = pc_off + EPV_SCALL_RET_INC;
        else if (k == 2 || k == 10 || k == 12 || k == 13 || k == 14 || k >= 16) exp_ret = pc_off;
        else exp_ret = pc_nc;
    endfunction

    task automatic check(input logic ok, input string what);
        check_count++;
        if (!ok)
        begin
            errors++;
            $display("BAD t=%0t %s", $time, what);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_take();
        int n;
        n = 0;
        while (take_ff !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n == 20)
        begin
            errors++;
            $display("BAD t=%0t no event taken", $time);
            finish_test();
        end
    endtask

    // waits for event k, checks what is presented, drops the source, acknowledges
    task automatic take_check(input int k);
        wait_take();
        check(take_pri_ff === PRI_TAB[k], "priority number");
        check(handler_addr_ff === exp_hdl(k), "handler address");
        check(return_addr_ff === exp_ret(k), "return address");
        check(return_valid_ff === (k != 0), "return valid");
        @(posedge clk_sys);
        ev_on[k] <= 1'b0;
        cls <= 6'h00;
        repeat (3) @(posedge clk_sys);
        #1 check(take_ff === 1'b1 && handler_addr_ff === exp_hdl(k), "outputs not held");
        @(posedge clk_sys);
        take_ack <= 1'b1;
        @(posedge clk_sys);
        take_ack <= 1'b0;
        #1 check(take_ff === 1'b0, "take not released by ack");
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_single();
        for (int k = 0; k < 18; k++)
        begin
            @(posedge clk_sys);
            ev_on[k] <= 1'b1;
            take_check(k);
            repeat (4) @(posedge clk_sys);
            #1 check(take_ff === 1'b0, "retaken after drop");
        end
        $display("test single done");
    endtask

    task automatic test_priority();
        @(posedge clk_sys);
        base <= 32'h8000_0000;
        ev_on <= 18'h3FFFF;
        for (int k = 0; k < 18; k++)
            take_check(k);
        $display("test priority done");
    endtask

    task automatic test_unimpl();
        logic [5:0] cases [0:4];
        cases = '{6'h01, 6'h02, 6'h08, 6'h10, 6'h20};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys);
            cls <= cases[i];
            take_check(13);
        end
        @(posedge clk_sys);
        cls <= 6'h06;
        repeat (5) @(posedge clk_sys);
        #1 check(take_ff === 1'b0, "present coprocessor raised");
        @(posedge clk_sys);
        cls <= 6'h00;
        $display("test unimplemented done");
    endtask

    task automatic test_reset_mid();
        @(posedge clk_sys);
        ev_on[12] <= 1'b1;
        wait_take();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        ev_on[12] <= 1'b0;
        #1 check(take_ff === 1'b0 && handler_addr_ff === 32'h0, "outputs not cleared");
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(take_ff === 1'b0, "take after reset with no event");
        @(posedge clk_sys);
        ev_on[12] <= 1'b1;
        take_check(12);
        $display("test mid reset done");
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        test_single();
        test_priority();
        test_unimpl();
        test_reset_mid();
        finish_test();
    end
endmodule
`default_nettype wire
